//--- logic/rpt_pkg.sv
// Package for the pattern reload timer: register map, field layout,
// reset values and bus carrier types.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package rpt_pkg;

    // Register byte offsets
    localparam logic [7:0] RPT_OFF_IRQ_CLEAR     = 8'h28;
    localparam logic [7:0] RPT_OFF_TIME_READBACK = 8'h2C;
    localparam logic [7:0] RPT_OFF_TIMER_CONTROL = 8'h30;
    localparam logic [7:0] RPT_OFF_FIRST_LOAD    = 8'h34;
    localparam logic [7:0] RPT_OFF_SECOND_LOAD   = 8'h38;
    localparam logic [7:0] RPT_OFF_PATTERN0      = 8'h3C;
    localparam logic [7:0] RPT_OFF_PATTERN1      = 8'h40;
    localparam logic [7:0] RPT_OFF_PATTERN2      = 8'h44;
    localparam logic [7:0] RPT_OFF_PATTERN3      = 8'h48;
    localparam logic [7:0] RPT_OFF_IRQ_NUMBER    = 8'h4C;
    localparam logic [7:0] RPT_OFF_IRQ_STATUS    = 8'h50;
    localparam logic [7:0] RPT_OFF_IRQ_ENABLE    = 8'h54;

    // Field positions
    localparam int RPT_BIT_WATCH_CLR  = 0;
    localparam int RPT_BIT_TIMER_CLR  = 1;
    localparam int RPT_BIT_ONE_SHOT   = 0;
    localparam int RPT_BIT_RUN_EN     = 1;
    localparam int RPT_BIT_SELF_START = 2;
    localparam int RPT_BIT_SIZE_LO    = 4;
    localparam int RPT_BIT_SIZE_HI    = 10;
    localparam int RPT_BIT_CLK_SEL    = 11;
    localparam int RPT_BIT_GATE_BYP   = 12;
    localparam int RPT_BIT_WATCH_IRQ  = 0;
    localparam int RPT_BIT_TIMER_IRQ  = 1;

    // Writable bits of timer_control
    localparam logic [31:0] RPT_CTRL_MASK    = 32'h0000_1FF7;

    // Reset values and unmapped read value
    localparam logic [31:0] RPT_RST_READBACK = 32'h0FFF_FFFF;
    localparam logic [31:0] RPT_RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RPT_READ_UNMAPPED = 32'h0000_0000;

    // Pattern geometry
    localparam int RPT_PAT_WORDS = 4;
    localparam int RPT_PAT_BITS  = 128;

    // Avalon-MM request carrier
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rpt_bus_req_type;

    // Slave access FSM, one-hot
    typedef enum logic [1:0] {
        RPT_BUS_IDLE = 2'b01,
        RPT_BUS_ACK  = 2'b10
    } rpt_bus_state_type;

endpackage

//--- logic/rpt_sync.sv
// Two-flop synchroniser for one level from another clock domain.
// Assumes the input is a level that stays stable for several clocks.
`timescale 1ns/100ps
`default_nettype none
module rpt_sync
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // Level in and out
    input  wire logic async_i,
    output var  logic sync_o
);

    logic meta_r;

    // First flop feeds only the second one
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule
`default_nettype wire

//--- logic/rpt_tick.sv
// Rising-edge detector that turns a synchronised tick level into a pulse.
// Assumes its input already passed a synchroniser.
`timescale 1ns/100ps
`default_nettype none
module rpt_tick
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // Level in, one-cycle pulse out
    input  wire logic level_i,
    output var  logic pulse_o
);

    logic last_r;

    // Previous level kept for edge compare
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            last_r <= 1'b0;
        else
            last_r <= level_i;
    end

    assign pulse_o = level_i & ~last_r;

endmodule
`default_nettype wire

//--- logic/rpt_timer.sv
// Pattern reload down-counter with its register file on Avalon-MM.
// Assumes slow_clock and trimmed clock arrive as asynchronous levels,
// the clockwatch interrupt source arrives as a pulse on ref_clk_i.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module rpt_timer
    import rpt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    // Timer clocks, asynchronous levels
    input  wire logic        slow_clock_i,
    input  wire logic        trimmed_clock_i,
    // Clockwatch event pulse
    input  wire logic        watch_event_i,
    // Interrupt lines and timer clock enable
    output var  logic        watch_irq_line_o,
    output var  logic        timer_irq_line_o,
    output var  logic        timer_clk_enabled_o
);

    rpt_bus_req_type   req;
    rpt_bus_state_type bus_state_r;
    logic [31:0] control_r;
    logic [31:0] first_load_r;
    logic [31:0] second_load_r;
    logic [31:0] pattern_r [RPT_PAT_WORDS];
    logic [31:0] irq_number_r;
    logic [31:0] count_r;
    logic [31:0] readback_r;
    logic [6:0]  pointer_r;
    logic        timer_raw_r;
    logic        watch_raw_r;
    logic        timer_en_r;
    logic        irq_enable_r;
    logic        slow_sync;
    logic        trim_sync;
    logic        slow_tick;
    logic        trim_tick;
    logic        tick;
    logic        do_write;
    logic        do_read;
    logic        load_wr;
    logic        pat_wr;
    logic        clr_wr;
    logic        hit_zero;
    logic        pat_bit;
    logic [6:0]  pat_size;
    logic [31:0] reload_val;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic [127:0] pattern_flat;

    assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                   writedata: avs_writedata_i, byteenable: avs_byteenable_i};

    // Clock crossings for both timer clocks
    rpt_sync u_sync_slow
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (slow_clock_i),
        .sync_o    (slow_sync)
    );
    rpt_sync u_sync_trim
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (trimmed_clock_i),
        .sync_o    (trim_sync)
    );

    // Edge detect on the synchronised levels only; a raw pin edge
    // sampled directly could be counted twice or not at all
    rpt_tick u_tick_slow
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (slow_sync),
        .pulse_o   (slow_tick)
    );
    rpt_tick u_tick_trim
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (trim_sync),
        .pulse_o   (trim_tick)
    );

    // Timer tick source and gating
    assign tick = (control_r[RPT_BIT_CLK_SEL] ? trim_tick : slow_tick)
                  & timer_en_r;

    // Bus decode: a write commits only at the edge that sees waitrequest
    // low, so a master still waiting can never half-complete a write;
    // a read is latched one edge earlier so its data stands at that edge
    assign do_write = (bus_state_r == RPT_BUS_ACK) && req.write;
    assign do_read  = (bus_state_r == RPT_BUS_IDLE) && req.read;
    assign wmask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign load_wr = do_write && (req.address == RPT_OFF_FIRST_LOAD
                                  || req.address == RPT_OFF_SECOND_LOAD);
    assign pat_wr  = do_write && (req.address >= RPT_OFF_PATTERN0)
                     && (req.address <= RPT_OFF_PATTERN3);
    assign clr_wr  = do_write && (req.address == RPT_OFF_IRQ_CLEAR);

    // Pattern view and reload choice
    assign pattern_flat = {pattern_r[3], pattern_r[2], pattern_r[1], pattern_r[0]};
    assign pat_size   = control_r[RPT_BIT_SIZE_HI:RPT_BIT_SIZE_LO];
    assign pat_bit    = pattern_flat[pointer_r];
    assign reload_val = pat_bit ? second_load_r : first_load_r;
    assign hit_zero   = tick && control_r[RPT_BIT_RUN_EN] && (count_r == 32'h0000_0000);

    // Avalon handshake: one wait cycle, answer in ACK
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bus_state_r       <= RPT_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            unique case (bus_state_r)
                RPT_BUS_IDLE:
                begin
                    if (req.read || req.write)
                    begin
                        bus_state_r       <= RPT_BUS_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                RPT_BUS_ACK:
                begin
                    bus_state_r       <= RPT_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default:
                begin
                    bus_state_r       <= RPT_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits give zero
    always_comb
    begin
        rdata = RPT_READ_UNMAPPED;
        unique case (req.address)
            RPT_OFF_TIME_READBACK: rdata = readback_r;
            RPT_OFF_TIMER_CONTROL: rdata = control_r & RPT_CTRL_MASK;
            RPT_OFF_FIRST_LOAD:    rdata = first_load_r;
            RPT_OFF_SECOND_LOAD:   rdata = second_load_r;
            RPT_OFF_PATTERN0:      rdata = pattern_r[0];
            RPT_OFF_PATTERN1:      rdata = pattern_r[1];
            RPT_OFF_PATTERN2:      rdata = pattern_r[2];
            RPT_OFF_PATTERN3:      rdata = pattern_r[3];
            RPT_OFF_IRQ_NUMBER:    rdata = irq_number_r;
            RPT_OFF_IRQ_STATUS:    rdata = {30'h0, timer_raw_r, watch_raw_r};
            RPT_OFF_IRQ_ENABLE:    rdata = {30'h0, irq_enable_r, 1'b0};
            default:               rdata = RPT_READ_UNMAPPED;
        endcase
    end

    // Read data registered so it stands at the ACK edge
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            avs_readdata_o <= RPT_RST_ZERO;
        else if (do_read)
            avs_readdata_o <= rdata;
    end

    // Timer interrupt enable bit
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_enable_r <= 1'b0;
        else if (do_write && req.address == RPT_OFF_IRQ_ENABLE && req.byteenable[0])
            irq_enable_r <= req.writedata[RPT_BIT_TIMER_IRQ];
    end

    // Control register: software writes, hardware sets and clears run-enable
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            control_r <= RPT_RST_ZERO;
        else
        begin
            if (do_write && req.address == RPT_OFF_TIMER_CONTROL)
                control_r <= (control_r & ~(wmask & RPT_CTRL_MASK))
                             | (req.writedata & wmask & RPT_CTRL_MASK);
            else if ((load_wr && !control_r[RPT_BIT_RUN_EN])
                     || ((load_wr || pat_wr) && control_r[RPT_BIT_SELF_START]))
                control_r[RPT_BIT_RUN_EN] <= 1'b1;
            else if (hit_zero && control_r[RPT_BIT_ONE_SHOT])
                control_r[RPT_BIT_RUN_EN] <= 1'b0;
        end
    end

    // Timer clock enable: gated to run-enable unless bypassed
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            timer_en_r <= 1'b0;
        else
            timer_en_r <= control_r[RPT_BIT_GATE_BYP] | control_r[RPT_BIT_RUN_EN];
    end

    // Load values, pattern and interrupt number
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            first_load_r  <= RPT_RST_ZERO;
            second_load_r <= RPT_RST_ZERO;
            irq_number_r  <= RPT_RST_ZERO;
            for (int i = 0; i < RPT_PAT_WORDS; i++)
                pattern_r[i] <= RPT_RST_ZERO;
        end
        else if (do_write)
        begin
            unique case (req.address)
                RPT_OFF_FIRST_LOAD:
                    first_load_r <= (first_load_r & ~wmask) | (req.writedata & wmask);
                RPT_OFF_SECOND_LOAD:
                    second_load_r <= (second_load_r & ~wmask) | (req.writedata & wmask);
                RPT_OFF_PATTERN0:
                    pattern_r[0] <= (pattern_r[0] & ~wmask) | (req.writedata & wmask);
                RPT_OFF_PATTERN1:
                    pattern_r[1] <= (pattern_r[1] & ~wmask) | (req.writedata & wmask);
                RPT_OFF_PATTERN2:
                    pattern_r[2] <= (pattern_r[2] & ~wmask) | (req.writedata & wmask);
                RPT_OFF_PATTERN3:
                    pattern_r[3] <= (pattern_r[3] & ~wmask) | (req.writedata & wmask);
                RPT_OFF_IRQ_NUMBER:
                    irq_number_r <= (irq_number_r & ~wmask) | (req.writedata & wmask);
                default:
                    irq_number_r <= irq_number_r;
            endcase
        end
    end

    // Down-counter with pattern-driven reload
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_r    <= RPT_RST_ZERO;
            pointer_r  <= 7'h00;
            readback_r <= RPT_RST_READBACK;
        end
        else if (load_wr && !control_r[RPT_BIT_RUN_EN])
        begin
            // Fresh load while stopped restarts the sequence
            count_r    <= req.writedata;
            readback_r <= req.writedata;
            pointer_r  <= 7'h00;
        end
        else if (tick && control_r[RPT_BIT_RUN_EN])
        begin
            if (count_r == 32'h0000_0000)
            begin
                if (!control_r[RPT_BIT_ONE_SHOT])
                begin
                    count_r    <= reload_val;
                    readback_r <= reload_val;
                    pointer_r  <= (pointer_r >= pat_size) ? 7'h00
                                                          : pointer_r + 7'h01;
                end
            end
            else
                count_r <= count_r - 32'h0000_0001;
        end
    end

    // Raw interrupt flags: a set in the clearing cycle wins
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            timer_raw_r <= 1'b0;
            watch_raw_r <= 1'b0;
        end
        else
        begin
            if (hit_zero)
                timer_raw_r <= 1'b1;
            else if (clr_wr && req.byteenable[0] && req.writedata[RPT_BIT_TIMER_CLR])
                timer_raw_r <= 1'b0;
            if (watch_event_i)
                watch_raw_r <= 1'b1;
            else if (clr_wr && req.byteenable[0] && req.writedata[RPT_BIT_WATCH_CLR])
                watch_raw_r <= 1'b0;
        end
    end

    // Interrupt outputs registered; timer line is the masked status
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            watch_irq_line_o    <= 1'b0;
            timer_irq_line_o    <= 1'b0;
            timer_clk_enabled_o <= 1'b0;
        end
        else
        begin
            watch_irq_line_o    <= watch_raw_r;
            timer_irq_line_o    <= timer_raw_r & irq_enable_r;
            timer_clk_enabled_o <= timer_en_r;
        end
    end

endmodule
`default_nettype wire

//--- verif/rpt_timer_chk.sv
// Checker for the pattern reload timer: bus handshake, interrupt lines, gating.
// Sees only the top module ports; bound to every rpt_timer instance.
`timescale 1ns/100ps
`default_nettype none
module rpt_timer_chk
    import rpt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    // Timer side
    input  wire logic        watch_event_i,
    input  wire logic        watch_irq_line_o,
    input  wire logic        timer_irq_line_o,
    input  wire logic        timer_clk_enabled_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Writes commit at the waitrequest-low edge; reads latch one edge before
    logic take_w;
    logic take_r;
    logic clr_w;
    logic clr_t;
    assign take_w = avs_write_i && !avs_waitrequest_o;
    assign take_r = avs_read_i && avs_waitrequest_o;
    assign clr_w  = take_w && avs_address_i == 8'h28 && avs_writedata_i[0] && avs_byteenable_i[0];
    assign clr_t  = take_w && avs_address_i == 8'h28 && avs_writedata_i[1] && avs_byteenable_i[0];

    AST_WAIT_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("access not answered in one cycle");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_WAIT_IDLE: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
        |=> avs_waitrequest_o) else $error("waitrequest dropped with no access");
    AST_WATCH_CLEAR: assert property (
        clr_w && !watch_event_i |-> ##[1:2] !watch_irq_line_o)
        else $error("watch line stays up after a clear");
    AST_WATCH_KEEP: assert property (
        watch_irq_line_o && !clr_w && !$past(clr_w) |=> watch_irq_line_o)
        else $error("watch line dropped without a clear");
    AST_TIMER_CLEAR: assert property (
        clr_t && !timer_clk_enabled_o |-> ##[1:2] !timer_irq_line_o)
        else $error("timer line stays up after a clear");
    AST_MASK_OFF: assert property (
        take_w && avs_address_i == 8'h54 && !avs_writedata_i[1] && avs_byteenable_i[0]
        |-> ##[1:3] !timer_irq_line_o)
        else $error("timer line up while disabled");
    AST_UNMAPPED_READ: assert property (
        take_r && (avs_address_i < 8'h28 || avs_address_i > 8'h54) |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_RESERVED: assert property (
        take_r && avs_address_i == RPT_OFF_TIMER_CONTROL |=> (avs_readdata_o & ~RPT_CTRL_MASK) == 0)
        else $error("reserved control bits read nonzero");
    AST_BYPASS: assert property (
        take_w && avs_address_i == RPT_OFF_TIMER_CONTROL && avs_writedata_i[12]
        && avs_byteenable_i[1] |-> ##[1:3] timer_clk_enabled_o)
        else $error("gating bypass did not enable the timer clock");
endmodule

bind rpt_timer rpt_timer_chk i_chk
(
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .watch_event_i(watch_event_i),
    .watch_irq_line_o(watch_irq_line_o), .timer_irq_line_o(timer_irq_line_o),
    .timer_clk_enabled_o(timer_clk_enabled_o)
);
`default_nettype wire

//--- verif/rpt_timer_tb.sv
// Self-checking bench for the pattern reload timer.
// Drives bus, timer clocks and watch event itself; byte lanes always all on.
`timescale 1ns/100ps
`default_nettype none
module rpt_timer_tb
    import rpt_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] rst; logic [31:0] wd; logic [31:0] exp;} rpt_row_type;

    logic        ref_clk_i;
    logic        reset_n_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        slow_clock_i;
    logic        trimmed_clock_i;
    logic        watch_event_i;
    logic        watch_irq_line_o;
    logic        timer_irq_line_o;
    logic        timer_clk_enabled_o;
    logic [31:0] rdat;
    int          error_cnt;
    int          total_checks;
    // Register rows: address, reset value, write data, value read back
    rpt_row_type rows [11] = '{
        '{8'h2C, 32'h0FFF_FFFF, 32'h1234_5678, 32'h0FFF_FFFF},
        '{8'h30, 32'h0, 32'hFFFF_FFFF, 32'h0000_1FF7},
        '{8'h34, 32'h0, 32'h8765_4321, 32'h8765_4321},
        '{8'h38, 32'h0, 32'h0000_0003, 32'h0000_0003},
        '{8'h3C, 32'h0, 32'hA5A5_A5A5, 32'hA5A5_A5A5},
        '{8'h40, 32'h0, 32'h5A5A_5A5A, 32'h5A5A_5A5A},
        '{8'h44, 32'h0, 32'h0F0F_0F0F, 32'h0F0F_0F0F},
        '{8'h48, 32'h0, 32'hF0F0_F0F0, 32'hF0F0_F0F0},
        '{8'h4C, 32'h0, 32'hC3C3_3C3C, 32'hC3C3_3C3C},
        '{8'h54, 32'h0, 32'hFFFF_FFFF, 32'h0000_0002},
        '{8'h60, 32'h0, 32'hFFFF_FFFF, 32'h0}};

    rpt_timer i_dut
    (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .slow_clock_i(slow_clock_i),
        .trimmed_clock_i(trimmed_clock_i), .watch_event_i(watch_event_i),
        .watch_irq_line_o(watch_irq_line_o), .timer_irq_line_o(timer_irq_line_o),
        .timer_clk_enabled_o(timer_clk_enabled_o)
    );

    // 10 MHz reference clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Closing report, reached from the main sequence and from an expired wait
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One access, held until waitrequest is seen low; two edges then pass so
    // registered results have settled before anyone looks at them
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        avs_writedata_i <= d;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 40);
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        if (n >= 40)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: no bus answer", $time);
            report_and_stop();
        end
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    // Rising edges of one timer clock; spaced well beyond the synchroniser delay
    task automatic tick(input logic trimmed, input int cnt);
        repeat (cnt)
        begin
            repeat (6) @(posedge ref_clk_i);
            if (trimmed)
                trimmed_clock_i <= 1'b1;
            else
                slow_clock_i <= 1'b1;
            repeat (6) @(posedge ref_clk_i);
            trimmed_clock_i <= 1'b0;
            slow_clock_i    <= 1'b0;
        end
    endtask

    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask

    // Main sequence
    initial
    begin
        {reset_n_i, avs_read_i, avs_write_i, slow_clock_i, trimmed_clock_i} = '0;
        {watch_event_i, avs_address_i, avs_writedata_i} = '0;
        error_cnt = 0;
        total_checks = 0;
        do_reset();
        foreach (rows[i])
        begin
            rchk(rows[i].a, rows[i].rst);
            bus(1'b1, rows[i].a, rows[i].wd);
            rchk(rows[i].a, rows[i].exp);
        end
        // Mid-run reset brings back the reset values
        do_reset();
        rchk(8'h30, 32'h0);
        rchk(8'h2C, 32'h0FFF_FFFF);
        // Periodic run over a two-bit pattern: first, second, first
        bus(1'b1, 8'h54, 32'h2);
        bus(1'b1, 8'h3C, 32'h2);
        bus(1'b1, 8'h30, 32'h10);
        bus(1'b1, 8'h34, 32'h2);
        bus(1'b1, 8'h38, 32'h1);
        rchk(8'h30, 32'h12);
        rchk(8'h2C, 32'h2);
        tick(1'b0, 2);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        tick(1'b0, 1);
        chk({31'h0, timer_irq_line_o}, 32'h1);
        rchk(8'h2C, 32'h2);
        bus(1'b1, 8'h28, 32'h0);
        chk({31'h0, timer_irq_line_o}, 32'h1);
        bus(1'b1, 8'h28, 32'h2);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        tick(1'b0, 3);
        rchk(8'h2C, 32'h1);
        bus(1'b1, 8'h54, 32'h0);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        rchk(8'h50, 32'h2);
        bus(1'b1, 8'h54, 32'h2);
        chk({31'h0, timer_irq_line_o}, 32'h1);
        tick(1'b0, 2);
        rchk(8'h2C, 32'h2);
        // Stopped counter holds its count while ticks go by
        bus(1'b1, 8'h28, 32'h2);
        bus(1'b1, 8'h30, 32'h10);
        tick(1'b0, 4);
        bus(1'b1, 8'h30, 32'h12);
        tick(1'b0, 2);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        tick(1'b0, 1);
        chk({31'h0, timer_irq_line_o}, 32'h1);
        // One-shot on the trimmed clock; slow ticks must not count
        bus(1'b1, 8'h28, 32'h2);
        bus(1'b1, 8'h30, 32'h801);
        bus(1'b1, 8'h34, 32'h1);
        tick(1'b0, 3);
        tick(1'b1, 1);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        tick(1'b1, 1);
        chk({31'h0, timer_irq_line_o}, 32'h1);
        rchk(8'h30, 32'h801);
        bus(1'b1, 8'h28, 32'h2);
        tick(1'b1, 3);
        chk({31'h0, timer_irq_line_o}, 32'h0);
        chk({31'h0, timer_clk_enabled_o}, 32'h0);
        // Pattern write starts the counter only with self-start set
        bus(1'b1, 8'h3C, 32'h1);
        rchk(8'h30, 32'h801);
        bus(1'b1, 8'h30, 32'h805);
        bus(1'b1, 8'h3C, 32'h1);
        rchk(8'h30, 32'h807);
        bus(1'b1, 8'h30, 32'h801);
        bus(1'b1, 8'h30, 32'h1001);
        @(posedge ref_clk_i);
        chk({31'h0, timer_clk_enabled_o}, 32'h1);
        // Clockwatch event, then a zero write and a real clear
        watch_event_i <= 1'b1;
        @(posedge ref_clk_i);
        watch_event_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        bus(1'b1, 8'h28, 32'h0);
        chk({31'h0, watch_irq_line_o}, 32'h1);
        bus(1'b1, 8'h28, 32'h1);
        chk({31'h0, watch_irq_line_o}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
